// *** rtl/adc_pkg.sv ***
package adc_pkg;
  localparam int CLK_NS = 5;
  localparam int DATA_W = 16;
  localparam int HALF_W = 8;
  typedef logic [DATA_W-1:0] code_t;
  typedef logic [HALF_W-1:0] half_t;

  // least times round up, longest times round down, never below one cycle
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_max(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CONV_TIME_NS = 610;
  localparam int START_LOW_NS = 20;
  localparam int QUIET_PRE_NS = 100;
  localparam int QUIET_POST_NS = 40;
  localparam int RESET_LOW_NS = 20;
  localparam int ABORT_NS = 50;
  localparam int RESUME_NS = 20;
  localparam int FIRST_SAMPLE_NS = 20;

  localparam int CONV_MAX_CYC = cyc_max(CONV_TIME_NS);
  localparam int START_LOW_CYC = cyc_min(START_LOW_NS);
  localparam int QUIET_PRE_CYC = cyc_min(QUIET_PRE_NS);
  localparam int QUIET_POST_CYC = cyc_min(QUIET_POST_NS);
  localparam int RESET_LOW_CYC = cyc_min(RESET_LOW_NS);
  localparam int ABORT_MAX_CYC = cyc_max(ABORT_NS);
  localparam int RESUME_MAX_CYC = cyc_max(RESUME_NS);
  localparam int FIRST_SAMPLE_CYC = cyc_max(FIRST_SAMPLE_NS);

  localparam int SYNC_STAGES = 2;
  localparam int OSC_DIV = 7;
  localparam int SAR_BUSY_CYC = DATA_W * OSC_DIV;
  localparam int WARMUP_CONV = 3;
  localparam int READ_SETTLE_CYC = 6;
  localparam int HOST_RESET_CYC = RESET_LOW_CYC + 2;
  localparam int FIFO_DEPTH = 8;

  localparam code_t SIGN_FLIP = 16'h8000;
  localparam code_t CODE_POS_FS = 16'h7fff;
  localparam code_t CODE_MID = 16'h0000;
  localparam code_t CODE_NEG_FS = 16'h8000;
  localparam half_t HALF_ONES = 8'hff;
endpackage

// *** rtl/adc_link_if.sv ***
`timescale 1ns/10ps
interface adc_link_if;
  logic conversion_start_n;
  logic cs_n;
  logic rd_n;
  logic half_sel;
  logic reset_n;
  logic busy;
  adc_pkg::code_t data_out;
  logic data_oe;
  wire [adc_pkg::DATA_W-1:0] data_pins;

  // no tristate in logic: a released bus shows the inverse, so a late sample is caught
  assign data_pins = data_oe ? data_out : ~data_out;

  modport device_mp(
    input conversion_start_n, cs_n, rd_n, half_sel, reset_n,
    output busy, data_out, data_oe
  );
  modport host_mp(
    output conversion_start_n, cs_n, rd_n, half_sel, reset_n,
    input busy, data_pins
  );
endinterface

// *** rtl/adc_device.sv ***
`timescale 1ns/10ps
// Behaviour
// R1: conversion ends within 610 ns, internal clock
// R2: host holds start low 20 ns, cs low
// R3: start falling edge stops sampling, holds input
// R4: busy high through conversion, low at end
// R5: sampling restarts at later of busy/cs fall
// R6: cs must be low when start falls
// R7: data pins driven only while cs, rd low
// R8: host never reads in start quiet window
// R9: result is 16-bit two's complement code
// R10: half-select low gives full word on pins
// R11: half-select high: low byte up, ones below
// R12: byte host reads upper pins twice, high first
// R13: reset pin asynchronous, active low, ignores cs
// R14: reset aborts conversion, clears output latches
// R15: first sampling starts 20 ns after reset release
// R16: host resets then runs three warm-up conversions
// R17: conversion timed by modelled oscillator cycles
module adc_device (
  input logic clk,
  input logic rst_n,
  adc_link_if.device_mp link,
  input adc_pkg::code_t analog_code,
  output logic sampling,
  output logic holding,
  output adc_pkg::code_t last_result,
  output logic conv_done
);
  import adc_pkg::*;

  typedef enum logic [2:0] {
    D_RESET,
    D_FIRST,
    D_SAMPLE,
    D_CONV,
    D_WAIT_CS
  } dev_state_t;

  localparam int FIRST_WAIT = (FIRST_SAMPLE_CYC > SYNC_STAGES + 1) ?
                              FIRST_SAMPLE_CYC - SYNC_STAGES - 1 : 1;
  localparam logic [3:0] FIRST_WAIT_V = 4'(FIRST_WAIT);
  localparam logic [2:0] OSC_LAST = 3'(OSC_DIV - 1);
  localparam logic [3:0] TOP_BIT = 4'(DATA_W - 1);

  logic [1:0] startn_sq;
  logic [1:0] csn_sq;
  logic [1:0] rdn_sq;
  logic [1:0] half_sq;
  logic [1:0] rstn_sq;
  logic startn_prev_q;
  logic csn_prev_q;
  dev_state_t state_q;
  logic [3:0] wait_q;
  logic [2:0] osc_q;
  logic [3:0] bit_q;
  code_t held_q;
  code_t trial_q;
  code_t result_q;
  logic busy_q;
  logic done_q;
  code_t data_q;
  logic oe_q;

  logic start_fall;
  logic cs_fall;
  logic pin_reset;
  logic osc_tick;
  logic sar_done;
  logic take_start;
  code_t cand;
  code_t final_code;

  // pins cross into clk via two flops; the first flop feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startn_sq <= 2'b11;
      csn_sq <= 2'b11;
      rdn_sq <= 2'b11;
      half_sq <= 2'b00;
      rstn_sq <= 2'b00;
    end else begin
      startn_sq <= {startn_sq[0], link.conversion_start_n};
      csn_sq <= {csn_sq[0], link.cs_n};
      rdn_sq <= {rdn_sq[0], link.rd_n};
      half_sq <= {half_sq[0], link.half_sel};
      rstn_sq <= {rstn_sq[0], link.reset_n};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startn_prev_q <= 1'b1;
      csn_prev_q <= 1'b1;
    end else begin
      startn_prev_q <= startn_sq[1];
      csn_prev_q <= csn_sq[1];
    end
  end

  assign start_fall = startn_prev_q & ~startn_sq[1];
  assign cs_fall = csn_prev_q & ~csn_sq[1];
  // reset pin needs no chip select; three cycles of latency stay inside 50 ns
  assign pin_reset = ~rstn_sq[1]; // R13
  assign take_start = (state_q == D_SAMPLE) && start_fall && !csn_sq[1]; // R3 R6
  assign osc_tick = (osc_q == OSC_LAST);
  assign sar_done = (state_q == D_CONV) && osc_tick && (bit_q == 4'h0);
  assign cand = trial_q | (code_t'(1) << bit_q);
  assign final_code = (cand <= held_q) ? cand : trial_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= D_RESET;
    end else if (pin_reset) begin
      state_q <= D_RESET; // R14
    end else begin
      case (state_q)
        D_RESET: begin
          state_q <= D_FIRST;
        end
        D_FIRST: begin
          if (wait_q == 4'h0) begin
            state_q <= D_SAMPLE; // R15
          end
        end
        D_SAMPLE: begin
          if (take_start) begin
            state_q <= D_CONV; // R3
          end
        end
        D_CONV: begin
          if (sar_done) begin
            // cs already low means busy falls last, so sampling starts now
            state_q <= csn_sq[1] ? D_WAIT_CS : D_SAMPLE; // R5
          end
        end
        D_WAIT_CS: begin
          if (cs_fall) begin
            state_q <= D_SAMPLE; // R5
          end
        end
        default: begin
          state_q <= D_RESET;
        end
      endcase
    end
  end

  // first sampling period after reset ignores busy and cs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
    end else if (state_q == D_RESET) begin
      wait_q <= FIRST_WAIT_V; // R15
    end else if (state_q == D_FIRST && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
  end

  // modelled internal oscillator, one tick per result bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_q <= 3'h0;
    end else if (state_q != D_CONV || osc_tick) begin
      osc_q <= 3'h0; // R17
    end else begin
      osc_q <= osc_q + 3'h1; // R1
    end
  end

  // offset binary internally so the compare is unsigned
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_q <= CODE_MID;
      trial_q <= CODE_MID;
      bit_q <= 4'h0;
    end else if (pin_reset) begin
      trial_q <= CODE_MID;
      bit_q <= 4'h0;
    end else if (take_start) begin
      held_q <= analog_code ^ SIGN_FLIP; // R3
      trial_q <= CODE_MID;
      bit_q <= TOP_BIT;
    end else if (state_q == D_CONV && osc_tick) begin
      trial_q <= final_code;
      if (bit_q != 4'h0) begin
        bit_q <= bit_q - 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= CODE_MID;
    end else if (pin_reset) begin
      result_q <= CODE_MID; // R14
    end else if (sar_done) begin
      result_q <= final_code ^ SIGN_FLIP; // R9
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (pin_reset || sar_done) begin
      busy_q <= 1'b0; // R4 R14
    end else if (take_start) begin
      busy_q <= 1'b1; // R4
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= sar_done && !pin_reset;
    end
  end

  // bus follows the latched result; ones fill the lower pins in half mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= CODE_MID;
      oe_q <= 1'b0;
    end else begin
      oe_q <= !csn_sq[1] && !rdn_sq[1] && !pin_reset; // R7
      if (pin_reset) begin
        data_q <= CODE_MID; // R14
      end else if (half_sq[1]) begin
        data_q <= {result_q[HALF_W-1:0], HALF_ONES}; // R11
      end else begin
        data_q <= result_q; // R10
      end
    end
  end

  assign link.busy = busy_q;
  assign link.data_out = data_q;
  assign link.data_oe = oe_q;
  assign sampling = (state_q == D_SAMPLE);
  assign holding = (state_q == D_CONV);
  assign last_result = result_q;
  assign conv_done = done_q;
endmodule

// *** rtl/adc_host.sv ***
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input logic clk,
  input logic rst_n,
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // depth must be a power of two for the wrap bit to work
  assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = (wr_q != rd_q);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

module adc_host (
  input logic clk,
  input logic rst_n,
  adc_link_if.host_mp link,
  input logic start_req,
  input logic byte_mode,
  output logic host_ready,
  output logic warm,
  output logic res_valid,
  input logic res_ready,
  output adc_pkg::code_t res_data
);
  import adc_pkg::*;

  typedef enum logic [3:0] {
    H_RST, H_POST, H_IDLE, H_START, H_WBUSY, H_CONV,
    H_RD_HI, H_RD_LO, H_PUSH, H_GAP
  } host_state_t;

  localparam logic [7:0] RST_V = 8'(HOST_RESET_CYC);
  localparam logic [7:0] START_V = 8'(START_LOW_CYC);
  localparam logic [7:0] READ_V = 8'(READ_SETTLE_CYC);
  // extra cycles cover the device's input synchronisers
  localparam logic [7:0] GAP_V = 8'(QUIET_PRE_CYC + SYNC_STAGES + 1);
  localparam logic [1:0] WARM_V = 2'(WARMUP_CONV);

  host_state_t state_q;
  logic [7:0] cnt_q;
  logic [1:0] warm_q;
  logic [1:0] busy_sq;
  code_t pins_s0_q;
  code_t pins_s1_q;
  code_t word_q;
  logic bmode_q;
  logic fifo_ready;
  logic cnt_zero;

  assign cnt_zero = (cnt_q == 8'h00);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_sq <= 2'b00;
      pins_s0_q <= CODE_MID;
      pins_s1_q <= CODE_MID;
    end else begin
      busy_sq <= {busy_sq[0], link.busy};
      pins_s0_q <= link.data_pins;
      pins_s1_q <= pins_s0_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= H_RST;
      cnt_q <= RST_V;
    end else begin
      cnt_q <= cnt_zero ? 8'h00 : cnt_q - 8'h01;
      case (state_q)
        H_RST: if (cnt_zero) begin
          state_q <= H_POST; // R13
          cnt_q <= GAP_V;
        end
        H_POST: if (cnt_zero) begin
          state_q <= H_IDLE;
        end
        H_IDLE: if (warm_q != WARM_V || start_req) begin
          state_q <= H_START; // R16
          cnt_q <= START_V;
        end
        H_START: if (cnt_zero) begin
          state_q <= H_WBUSY; // R2
        end
        H_WBUSY: if (busy_sq[1]) begin
          state_q <= H_CONV;
        end
        H_CONV: if (!busy_sq[1]) begin
          state_q <= H_RD_HI; // R8
          cnt_q <= READ_V;
        end
        H_RD_HI: if (cnt_zero) begin
          state_q <= bmode_q ? H_RD_LO : (warm_q == WARM_V ? H_PUSH : H_GAP);
          cnt_q <= bmode_q ? READ_V : GAP_V;
        end
        H_RD_LO: if (cnt_zero) begin
          state_q <= (warm_q == WARM_V) ? H_PUSH : H_GAP; // R12
          cnt_q <= GAP_V;
        end
        H_PUSH: begin
          cnt_q <= GAP_V;
          if (fifo_ready) begin
            state_q <= H_GAP;
          end
        end
        H_GAP: if (cnt_zero) begin
          state_q <= H_IDLE; // R8
        end
        default: state_q <= H_RST;
      endcase
    end
  end

  // warm-up results are read but never delivered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warm_q <= 2'h0;
    end else if (state_q == H_GAP && cnt_zero && warm_q != WARM_V) begin
      warm_q <= warm_q + 2'h1; // R16
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bmode_q <= 1'b0;
      word_q <= CODE_MID;
    end else if (state_q == H_IDLE) begin
      bmode_q <= byte_mode;
    end else if (state_q == H_RD_HI && cnt_zero) begin
      word_q <= bmode_q ? {pins_s1_q[DATA_W-1:HALF_W], HALF_ONES} : pins_s1_q; // R12
    end else if (state_q == H_RD_LO && cnt_zero) begin
      word_q <= {word_q[DATA_W-1:HALF_W], pins_s1_q[DATA_W-1:HALF_W]}; // R12
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.reset_n <= 1'b0;
      link.cs_n <= 1'b1;
      link.conversion_start_n <= 1'b1;
      link.rd_n <= 1'b1;
      link.half_sel <= 1'b0;
    end else begin
      link.reset_n <= (state_q != H_RST); // R13
      link.cs_n <= (state_q == H_RST); // R6
      link.conversion_start_n <= !(state_q == H_IDLE &&
                                   (warm_q != WARM_V || start_req)) &&
                                 !(state_q == H_START && !cnt_zero); // R2
      link.rd_n <= !((state_q == H_CONV && !busy_sq[1]) ||
                     (state_q == H_RD_HI && !(cnt_zero && !bmode_q)) ||
                     (state_q == H_RD_LO && !cnt_zero));
      link.half_sel <= (state_q == H_RD_HI && cnt_zero && bmode_q) ||
                       (state_q == H_RD_LO && !cnt_zero); // R12
    end
  end

  // a full queue parks the host in H_PUSH, so no new conversion starts
  sample_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(state_q == H_PUSH),
    .in_ready(fifo_ready),
    .in_data(word_q),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  assign host_ready = (state_q == H_IDLE) && (warm_q == WARM_V);
  assign warm = (warm_q == WARM_V);
endmodule

// *** test/adc_link_checker.sv ***
`timescale 1ns/10ps
module adc_link_checker (
  input logic clk,
  input logic rst_n,
  input logic conversion_start_n,
  input logic cs_n,
  input logic rd_n,
  input logic half_sel,
  input logic reset_n,
  input logic busy,
  input adc_pkg::code_t data_out,
  input logic data_oe,
  input wire [adc_pkg::DATA_W-1:0] data_pins
);
  import adc_pkg::*;
  int busy_cnt_q;
  int idle_rd_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      busy_cnt_q <= 0;
    else
      busy_cnt_q <= busy ? busy_cnt_q + 1 : 0;
  end

  // saturates so a long idle stretch never wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      idle_rd_q <= 1000;
    else if (!cs_n && !rd_n)
      idle_rd_q <= 0;
    else if (idle_rd_q < 1000)
      idle_rd_q <= idle_rd_q + 1;
  end

  AST_BUSY_MAX: assert property (busy_cnt_q <= CONV_MAX_CYC)
    else $error("busy longer than conversion limit");
  AST_BUSY_LEN: assert property ($fell(busy) && reset_n |-> busy_cnt_q == SAR_BUSY_CYC)
    else $error("busy length not oscillator count");
  AST_BUSY_RISE: assert property ($fell(conversion_start_n) && !cs_n && !busy && reset_n
    |-> ##[1:6] busy)
    else $error("busy did not rise after start");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> !$past(conversion_start_n, 2))
    else $error("busy rose without start");
  AST_START_CS: assert property ($fell(conversion_start_n) |-> !cs_n)
    else $error("start fell with chip select high");
  AST_START_WIDTH: assert property ($fell(conversion_start_n) |=> !conversion_start_n [*3])
    else $error("start pulse too short");
  AST_QUIET_PRE: assert property ($fell(conversion_start_n) |-> idle_rd_q >= QUIET_PRE_CYC)
    else $error("read too close before start");
  AST_QUIET_POST: assert property ($fell(conversion_start_n) |-> (cs_n || rd_n) [*8])
    else $error("read too close after start");
  AST_OE_OFF: assert property ((cs_n || rd_n) [*5] |-> !data_oe)
    else $error("data pins driven without read");
  AST_OE_ON: assert property ((!cs_n && !rd_n && reset_n) [*5] |-> data_oe)
    else $error("data pins not driven during read");
  AST_BYTE_ONES: assert property ((data_oe && half_sel) [*5] |-> data_pins[7:0] == HALF_ONES)
    else $error("lower pins not all ones in byte mode");
  AST_RESET_CLEAR: assert property ((!reset_n) [*6] |-> !busy && data_out == '0)
    else $error("reset did not abort and clear");
  AST_RESET_LEN: assert property ($rose(reset_n) |-> !$past(reset_n, 4))
    else $error("reset pulse too short");

  cover property ($fell(busy));
  cover property (data_oe && half_sel);
  cover property ($rose(reset_n));
endmodule

// *** test/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  import adc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start_req = 1'b0;
  logic byte_mode = 1'b0;
  logic res_ready = 1'b0;
  code_t analog_code = '0;
  logic host_ready, warm, res_valid, sampling, holding, conv_done;
  code_t res_data, last_result;
  int miscompares = 0;
  int num_checks = 0;
  code_t exp_q[$];
  code_t corner[3] = '{CODE_POS_FS, CODE_MID, CODE_NEG_FS};

  always #2.5 clk = ~clk;

  adc_link_if adc_link_if_inst ();
  adc_device adc_device_inst (.clk(clk), .rst_n(rst_n), .link(adc_link_if_inst.device_mp),
    .analog_code(analog_code), .sampling(sampling), .holding(holding),
    .last_result(last_result), .conv_done(conv_done));
  adc_host adc_host_inst (.clk(clk), .rst_n(rst_n), .link(adc_link_if_inst.host_mp),
    .start_req(start_req), .byte_mode(byte_mode), .host_ready(host_ready), .warm(warm),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
  adc_link_checker adc_link_checker_inst (.clk(clk), .rst_n(rst_n),
    .conversion_start_n(adc_link_if_inst.conversion_start_n), .cs_n(adc_link_if_inst.cs_n),
    .rd_n(adc_link_if_inst.rd_n), .half_sel(adc_link_if_inst.half_sel),
    .reset_n(adc_link_if_inst.reset_n), .busy(adc_link_if_inst.busy),
    .data_out(adc_link_if_inst.data_out), .data_oe(adc_link_if_inst.data_oe),
    .data_pins(adc_link_if_inst.data_pins));

  // ideal converter: input code comes back unchanged, in either read mode
  function automatic code_t ideal_code(input code_t a);
    return a;
  endfunction

  task automatic test_done();
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string name, input code_t exp, input code_t got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  typedef enum {SIG_READY, SIG_DONE, SIG_VALID, SIG_HOLD, SIG_SAMPLE} watch_t;

  // signals picked by name, so no reference to a port-driven variable is needed
  function automatic logic pick(input watch_t which);
    case (which)
      SIG_READY: return host_ready;
      SIG_DONE: return conv_done;
      SIG_VALID: return res_valid;
      SIG_HOLD: return holding;
      default: return sampling;
    endcase
  endfunction

  task automatic wait_for(input watch_t which, input logic val, input int lim);
    int n;
    n = 0;
    while (pick(which) !== val && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (pick(which) !== val) begin
      miscompares++;
      $display("CHECK FAILED wait %s expected %h seen %h", which.name(), val, pick(which));
      test_done();
    end
  endtask

  // analog_code held until the next request, so the sample edge always sees it
  task automatic request(input code_t code, input logic bm);
    wait_for(SIG_READY, 1'b1, 2000);
    analog_code = code;
    byte_mode = bm;
    start_req = 1'b1;
    wait_for(SIG_READY, 1'b0, 10);
    start_req = 1'b0;
    exp_q.push_back(ideal_code(code));
    wait_for(SIG_DONE, 1'b1, 300);
    check("last_result", ideal_code(code), last_result);
  endtask

  // one idle edge after each pop, so ready never drops and rises in one step
  task automatic pop_check();
    code_t exp;
    exp = exp_q.pop_front();
    wait_for(SIG_VALID, 1'b1, 500);
    check("res_data", exp, res_data);
    res_ready = 1'b1;
    @(negedge clk);
    res_ready = 1'b0;
    @(negedge clk);
  endtask

  initial begin
    code_t c;
    void'($urandom(32'h94718084));
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    wait_for(SIG_READY, 1'b1, 2000);
    check("warm", 16'h0001, {15'h0000, warm});
    check("res_valid", 16'h0000, {15'h0000, res_valid});
    // corners first, then random codes, word and byte reads alternating
    for (int i = 0; i < 9; i++) begin
      c = (i < 3) ? corner[i] : code_t'($urandom);
      request(c, i[0]);
    end
    repeat (300) @(negedge clk);
    check("host_ready", 16'h0000, {15'h0000, host_ready});
    check("res_valid", 16'h0001, {15'h0000, res_valid});
    repeat (9) pop_check();
    repeat (50) @(negedge clk);
    check("res_valid", 16'h0000, {15'h0000, res_valid});
    // reset in mid conversion must abort and restart sampling unprompted
    wait_for(SIG_READY, 1'b1, 2000);
    analog_code = 16'h5a5a;
    start_req = 1'b1;
    wait_for(SIG_HOLD, 1'b1, 50);
    start_req = 1'b0;
    rst_n = 1'b0;
    @(negedge clk);
    check("busy", 16'h0000, {15'h0000, adc_link_if_inst.busy});
    check("last_result", 16'h0000, last_result);
    rst_n = 1'b1;
    wait_for(SIG_SAMPLE, 1'b1, 20);
    wait_for(SIG_READY, 1'b1, 2000);
    check("warm", 16'h0001, {15'h0000, warm});
    request(16'h8001, 1'b1);
    pop_check();
    test_done();
  end
endmodule
